// File: deser_pkg.sv
package deser_pkg;
	// Frame layout
	localparam int                DATA_BITS    = 10;
	localparam int                FRAME_BITS   = 12;
	localparam logic [3:0]        LAST_BIT     = 4'hb;
	localparam logic [3:0]        MID_BIT      = 4'h5;
	localparam int                START_POS    = 11;
	localparam int                STOP_POS     = 0;
	// Lock qualification, in frames
	localparam logic [2:0]        LOCK_FRAMES  = 3'h4;
	localparam logic [1:0]        LOSS_FRAMES  = 2'h2;
	// Register map, byte addresses
	localparam logic [7:0]        OFS_STATUS   = 8'h00;
	localparam logic [7:0]        OFS_MASK     = 8'h04;
	localparam logic [7:0]        OFS_STATE    = 8'h08;
	localparam logic [7:0]        OFS_CTRL     = 8'h0c;
	// Event bit positions in status and mask
	localparam int                EV_GAINED    = 0;
	localparam int                EV_LOST      = 1;
	localparam int                EV_BADFRAME  = 2;
	localparam int                EV_BITS      = 3;
	// Control bit positions
	localparam int                CTRL_UNLOCK  = 0;
	// Reset values
	localparam logic [2:0]        MASK_RESET   = 3'h0;
	localparam logic [0:0]        CTRL_RESET   = 1'h0;
	// Pin synchroniser lanes
	localparam int                PIN_LANES    = 5;
	localparam int                LN_SERIAL    = 0;
	localparam int                LN_LINKCLK   = 1;
	localparam int                LN_PDN       = 2;
	localparam int                LN_OUTEN     = 3;
	localparam int                LN_EDGE      = 4;
	localparam logic [4:0]        PIN_RESET    = 5'h00;

	// Operating states
	typedef enum logic [1:0] {
		ST_DOWN   = 2'b00,
		ST_INIT   = 2'b01,
		ST_XFER   = 2'b10,
		ST_RESYNC = 2'b11
	} deser_state_t;
endpackage

// File: pin_sync3.sv
`timescale 1ns/1ps
`default_nettype none
module pin_sync3 #(
	parameter int          WIDTH = 1
) (
	// Clock and reset
	input  wire logic             ref_clk,
	input  wire logic             rst,
	// Asynchronous pins and their settled copies
	input  wire logic [WIDTH-1:0] pins,
	output logic      [WIDTH-1:0] settled
);
	logic [WIDTH-1:0] s1_q;
	logic [WIDTH-1:0] s2_q;
	logic [WIDTH-1:0] s3_q;
	logic [WIDTH-1:0] agree;

	// Only the second and third stages are compared, never the first
	assign agree = ~(s2_q ^ s3_q);

	// Three stage chain
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
		end else begin
			s1_q <= pins;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	// A lane moves only once two stages agree
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			settled <= '0;
		end else begin
			settled <= (agree & s3_q) | (~agree & settled);
		end
	end
endmodule
`default_nettype wire

// File: link_edge.sv
`timescale 1ns/1ps
`default_nettype none
module link_edge (
	// Clock and reset
	input  wire logic ref_clk,
	input  wire logic rst,
	// Settled link clock and its rising edge strobe
	input  wire logic link_level,
	output logic      rise_pulse
);
	logic prev_q;

	// One cycle enable per link bit
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			prev_q     <= 1'b0;
			rise_pulse <= 1'b0;
		end else begin
			prev_q     <= link_level;
			rise_pulse <= link_level & ~prev_q;
		end
	end
endmodule
`default_nettype wire

// File: embedded_clock_deserializer_lock.sv
// Design decisions made here: the register offsets and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module embedded_clock_deserializer_lock (
	// Clock and reset
	input  wire logic       ref_clk,
	input  wire logic       rst,
	// Serial link, sampled on the link bit clock
	input  wire logic       serial_in,
	input  wire logic       link_bit_clk,
	// Control pins
	input  wire logic       power_down_n,
	input  wire logic       out_enable,
	input  wire logic       out_edge_select,
	// Parallel side, output enables low while driving
	output logic      [9:0] parallel_out,
	output logic            parallel_out_oe_n,
	output logic            recovered_clk,
	output logic            recovered_clk_oe_n,
	output logic            lock_n,
	// Register port
	input  wire logic [7:0] reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	output logic      [31:0] reg_rdata,
	output logic            irq
);
	logic [deser_pkg::PIN_LANES-1:0] pins_s;
	logic                            sample_en;
	logic                            bit_s;
	logic                            pdn_s;
	logic                            oen_s;
	logic                            edge_s;
	deser_pkg::deser_state_t         state_q;
	deser_pkg::deser_state_t         state_d;
	logic [11:0]                     sr_q;
	logic [11:0]                     sr_d;
	logic [3:0]                      bit_cnt_q;
	logic [3:0]                      bit_cnt_d;
	logic [2:0]                      good_q;
	logic [1:0]                      bad_q;
	logic                            hunting;
	logic                            frame_done;
	logic                            frame_ok;
	logic                            lock_reach;
	logic                            loss_reach;
	logic                            mid_frame;
	logic [9:0]                      word;
	logic [2:0]                      status_q;
	logic [2:0]                      status_d;
	logic [2:0]                      mask_q;
	logic [0:0]                      ctrl_q;
	logic [2:0]                      events;
	logic                            wr_status;
	logic                            wr_mask;
	logic                            wr_ctrl;
	logic [31:0]                     rd_mux;
	logic                            force_unlock;

	// Every control and link pin passes the three stage chain; rst and the register port do not
	// Link clock and serial bit share one chain, so their skew stays fixed
	pin_sync3 #(
		.WIDTH(deser_pkg::PIN_LANES)
	) i_pin_sync3 (
		.ref_clk (ref_clk),
		.rst     (rst),
		.pins    ({out_edge_select, out_enable, power_down_n, link_bit_clk, serial_in}),
		.settled (pins_s)
	);

	assign bit_s  = pins_s[deser_pkg::LN_SERIAL];
	assign pdn_s  = pins_s[deser_pkg::LN_PDN];
	assign oen_s  = pins_s[deser_pkg::LN_OUTEN];
	assign edge_s = pins_s[deser_pkg::LN_EDGE];

	// Link clock rise gives the bit sample enable
	link_edge i_link_edge (
		.ref_clk    (ref_clk),
		.rst        (rst),
		.link_level (pins_s[deser_pkg::LN_LINKCLK]),
		.rise_pulse (sample_en)
	);

	// Frame window: oldest bit is the start bit
	assign sr_d       = {sr_q[10:0], bit_s};
	assign frame_done = sample_en && (bit_cnt_q == deser_pkg::LAST_BIT);
	assign frame_ok   = sr_d[deser_pkg::START_POS] & ~sr_d[deser_pkg::STOP_POS];
	assign mid_frame  = sample_en && (bit_cnt_q == deser_pkg::MID_BIT);
	assign hunting    = (state_q == deser_pkg::ST_INIT) || (state_q == deser_pkg::ST_RESYNC);
	assign force_unlock = ctrl_q[deser_pkg::CTRL_UNLOCK];
	// Enough clean frames in a row qualifies lock
	assign lock_reach = frame_done && frame_ok && !force_unlock
		&& (good_q == deser_pkg::LOCK_FRAMES - 3'h1);
	assign loss_reach = frame_done && !frame_ok
		&& (bad_q == deser_pkg::LOSS_FRAMES - 2'h1);

	// First data bit after start lands on bit 0
	genvar gi;
	generate
		for (gi = 0; gi < deser_pkg::DATA_BITS; gi++) begin : g_word
			assign word[gi] = sr_d[deser_pkg::START_POS-1-gi];
		end
	endgenerate

	// Slip one bit after a bad frame while hunting
	assign bit_cnt_d = !sample_en ? bit_cnt_q :
		!frame_done ? bit_cnt_q + 4'h1 :
		(hunting && !frame_ok) ? deser_pkg::LAST_BIT : 4'h0;

	// State sequencing
	always_comb begin
		state_d = state_q;
		unique case (state_q)
			deser_pkg::ST_DOWN: begin
				state_d = deser_pkg::ST_INIT;
			end
			deser_pkg::ST_INIT, deser_pkg::ST_RESYNC: begin
				if (lock_reach) begin
					state_d = deser_pkg::ST_XFER;
				end
			end
			deser_pkg::ST_XFER: begin
				if (force_unlock || loss_reach) begin
					state_d = deser_pkg::ST_RESYNC;
				end
			end
		endcase
		if (!pdn_s) begin
			state_d = deser_pkg::ST_DOWN;
		end
	end

	// Bit and frame tracking
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			state_q   <= deser_pkg::ST_DOWN;
			sr_q      <= 12'h000;
			bit_cnt_q <= 4'h0;
		end else begin
			state_q   <= state_d;
			sr_q      <= sample_en ? sr_d : sr_q;
			bit_cnt_q <= (state_q == deser_pkg::ST_DOWN) ? 4'h0 : bit_cnt_d;
		end
	end

	// Clean and bad frame run lengths
	// Good count wraps under forced unlock; lock then waits for the next run
	always_ff @(posedge ref_clk) begin
		if (rst || !hunting) begin
			good_q <= 3'h0;
		end else if (frame_done) begin
			good_q <= frame_ok ? good_q + 3'h1 : 3'h0;
		end
	end

	// A single bad frame is tolerated to ride out a noise hit
	always_ff @(posedge ref_clk) begin
		if (rst || state_q != deser_pkg::ST_XFER) begin
			bad_q <= 2'h0;
		end else if (frame_done) begin
			bad_q <= frame_ok ? 2'h0 : bad_q + 2'h1;
		end
	end

	// Lock indicator and output enables follow the next state
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			lock_n             <= 1'b1;
			parallel_out_oe_n  <= 1'b1;
			recovered_clk_oe_n <= 1'b1;
		end else begin
			lock_n             <= state_d != deser_pkg::ST_XFER;
			parallel_out_oe_n  <= !(state_d == deser_pkg::ST_XFER && oen_s);
			recovered_clk_oe_n <= !(state_d == deser_pkg::ST_XFER && oen_s);
		end
	end

	// Data changes on the inactive edge, active edge falls mid frame
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			parallel_out  <= 10'h000;
			recovered_clk <= 1'b0;
		end else if (frame_done && state_d == deser_pkg::ST_XFER) begin
			parallel_out  <= word;
			recovered_clk <= ~edge_s;
		end else if (mid_frame && state_q == deser_pkg::ST_XFER) begin
			recovered_clk <= edge_s;
		end
	end

	// Register decode
	// Unmapped addresses read zero and ignore writes
	assign wr_status = reg_wr && reg_addr == deser_pkg::OFS_STATUS;
	assign wr_mask   = reg_wr && reg_addr == deser_pkg::OFS_MASK;
	assign wr_ctrl   = reg_wr && reg_addr == deser_pkg::OFS_CTRL;
	assign events[deser_pkg::EV_GAINED]   = state_q != deser_pkg::ST_XFER
		&& state_d == deser_pkg::ST_XFER;
	assign events[deser_pkg::EV_LOST]     = state_q == deser_pkg::ST_XFER
		&& state_d != deser_pkg::ST_XFER;
	assign events[deser_pkg::EV_BADFRAME] = state_q == deser_pkg::ST_XFER
		&& frame_done && !frame_ok;
	// Set beats a simultaneous write-one clear
	assign status_d = (status_q & ~(wr_status ? reg_wdata[2:0] : 3'h0)) | events;
	assign rd_mux =
		(reg_addr == deser_pkg::OFS_STATUS) ? {29'h0000_0000, status_q} :
		(reg_addr == deser_pkg::OFS_MASK)   ? {29'h0000_0000, mask_q} :
		(reg_addr == deser_pkg::OFS_STATE)  ? {29'h0000_0000, lock_n, state_q} :
		(reg_addr == deser_pkg::OFS_CTRL)   ? {31'h0000_0000, ctrl_q} : 32'h0000_0000;

	// Status, mask, control and interrupt
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			status_q <= 3'h0;
			mask_q   <= deser_pkg::MASK_RESET;
			ctrl_q   <= deser_pkg::CTRL_RESET;
			irq      <= 1'b0;
		end else begin
			status_q <= status_d;
			mask_q   <= wr_mask ? reg_wdata[2:0] : mask_q;
			ctrl_q   <= wr_ctrl ? reg_wdata[0:0] : ctrl_q;
			irq      <= |(status_d & mask_q);
		end
	end

	// Read data stands the cycle after the strobe only
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			reg_rdata <= 32'h0000_0000;
		end else begin
			reg_rdata <= reg_rd ? rd_mux : 32'h0000_0000;
		end
	end

	// Checks
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	a_lock_held_hunt: assert property (
		hunting |=> lock_n || $past(state_d) == deser_pkg::ST_XFER)
		else $error("lock indicator low while hunting");
	a_lock_on_gain: assert property (
		(hunting && lock_reach && pdn_s) |=> !lock_n ##0 state_q == deser_pkg::ST_XFER)
		else $error("lock not taken after clean frames");
	a_data_gated: assert property (
		!parallel_out_oe_n |-> !lock_n)
		else $error("data driven while unlocked");
	a_loss_float: assert property (
		$rose(lock_n) |-> parallel_out_oe_n && recovered_clk_oe_n)
		else $error("outputs driven after lock loss");
	a_oe_pair: assert property (
		parallel_out_oe_n == recovered_clk_oe_n)
		else $error("data and clock enables disagree");
	a_down_unlocked: assert property (
		state_q == deser_pkg::ST_DOWN |-> lock_n && parallel_out_oe_n)
		else $error("outputs active in power down");
	a_frame_word: assert property (
		(frame_done && frame_ok && state_q == deser_pkg::ST_XFER && pdn_s && !force_unlock)
		|=> parallel_out == $past(word))
		else $error("framed word not presented");
	a_frame_len: assert property (
		sample_en && state_q == deser_pkg::ST_XFER && bit_cnt_q != deser_pkg::LAST_BIT
		|=> !frame_done)
		else $error("frame closed early");
	a_clk_edge: assert property (
		(mid_frame && state_q == deser_pkg::ST_XFER && !frame_done) |=> recovered_clk == $past(edge_s))
		else $error("recovered clock edge wrong");
	a_down_state: assert property (
		!pdn_s |=> state_q == deser_pkg::ST_DOWN ##1 lock_n)
		else $error("power down not honoured");
	a_slip_hunt: assert property (
		(hunting && frame_done && !frame_ok && pdn_s) |=> bit_cnt_q == deser_pkg::LAST_BIT)
		else $error("no bit slip on bad frame");

	c_lock_gain: cover property ($fell(lock_n));
	c_lock_loss: cover property ($rose(lock_n) ##0 pdn_s);
	c_word_out:  cover property (!lock_n && $changed(parallel_out));
	c_irq:       cover property ($rose(irq));
	c_relock:    cover property (state_q == deser_pkg::ST_RESYNC ##1 state_q == deser_pkg::ST_XFER);
endmodule
`default_nettype wire

// File: serializer_model.sv
`timescale 1ns/1ps
`default_nettype none
module serializer_model #(
	parameter logic [9:0] SYNC_WORD = 10'h01f
) (
	// Word side of the sender
	input  wire logic [9:0] parallel_in,
	input  wire logic       in_edge_select,
	input  wire logic       pattern_request_a,
	input  wire logic       pattern_request_b,
	// Run control and stop bit corruption
	input  wire logic       run,
	input  wire logic       inject,
	// Serial link
	output logic            link_clk,
	output logic            serial_bit
);
	logic [11:0] frame;
	int          req_cnt;

	// Behavioural sender, one frame of twelve bit clocks per word clock
	initial begin
		link_clk = 1'b0;
		serial_bit = 1'b0;
		req_cnt = 0;
		forever begin
			if (!run) begin
				// Held back until initialised; clock stands, line keeps changing
				serial_bit = ~serial_bit;
				#200;
			end else begin
				// Patterns from the fifth held word clock on, stop once both low
				req_cnt = (pattern_request_a || pattern_request_b) ? req_cnt + 1 : 0;
				// Word latched at the frame boundary; in_edge_select is not used
				frame = {inject, (req_cnt >= 5) ? SYNC_WORD : parallel_in, 1'b1};
				// Twelve bits per word, data changed away from the rising edge
				for (int i = 0; i < 12; i++) begin
					serial_bit = frame[i];
					#100 link_clk = 1'b1; // word clock slowed to the bench bit clock
					#100 link_clk = 1'b0;
				end
			end
		end
	end
endmodule
`default_nettype wire

// File: embedded_clock_deserializer_lock_tb.sv
`timescale 1ns/1ps
`default_nettype none
module embedded_clock_deserializer_lock_tb;
	logic        ref_clk;
	logic        rst;
	logic        power_down_n;
	logic        out_enable;
	logic        out_edge_select;
	logic [7:0]  reg_addr;
	logic [31:0] reg_wdata;
	logic        reg_wr;
	logic        reg_rd;
	logic [9:0]  parallel_in;
	logic        run;
	logic        inject;
	wire         serial_in;
	wire         link_bit_clk;
	logic [9:0]  parallel_out;
	logic        parallel_out_oe_n;
	logic        recovered_clk;
	logic        recovered_clk_oe_n;
	logic        lock_n;
	logic [31:0] reg_rdata;
	logic        irq;
	int          err_total;
	int          n_compared;

	// Pin levels as a load would see them
	wire [9:0] rout_pins = parallel_out_oe_n ? 'z : parallel_out;
	wire       rclk_pin  = recovered_clk_oe_n ? 1'bz : recovered_clk;

	embedded_clock_deserializer_lock i_embedded_clock_deserializer_lock (
		.ref_clk(ref_clk), .rst(rst), .serial_in(serial_in), .link_bit_clk(link_bit_clk),
		.power_down_n(power_down_n), .out_enable(out_enable),
		.out_edge_select(out_edge_select), .parallel_out(parallel_out),
		.parallel_out_oe_n(parallel_out_oe_n), .recovered_clk(recovered_clk),
		.recovered_clk_oe_n(recovered_clk_oe_n), .lock_n(lock_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.irq(irq));

	// Lock fed straight back as the pattern request
	serializer_model i_serializer_model (
		.parallel_in(parallel_in), .in_edge_select(1'b1), .pattern_request_a(lock_n),
		.pattern_request_b(1'b0), .run(run), .inject(inject), .link_clk(link_bit_clk),
		.serial_bit(serial_in));

	initial begin
		ref_clk = 1'b0;
		forever #12.5 ref_clk = ~ref_clk;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			err_total++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask

	// Read data stands only in the cycle after the strobe
	task automatic chk_reg(input logic [7:0] a, input logic [31:0] exp);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1 chk(reg_rdata, exp);
	endtask

	// Bounded wait for the lock indicator, then judge it
	task automatic wait_lock(input logic lvl, input int lim);
		int n;
		n = 0;
		while (lock_n !== lvl && n < lim) begin
			@(posedge ref_clk);
			n++;
		end
		#1 chk({31'h0, lock_n}, {31'h0, lvl});
	endtask

	task automatic t_reset();
		chk({29'h0, lock_n, parallel_out_oe_n, recovered_clk_oe_n}, 32'h0000_0007);
		chk_reg(deser_pkg::OFS_STATE, 32'h0000_0004);
		@(posedge ref_clk);
		power_down_n <= 1'b1;
		repeat (400) @(posedge ref_clk);
		chk_reg(deser_pkg::OFS_STATE, 32'h0000_0005);
		$display("test reset done");
	endtask

	task automatic t_lock(input logic sel, input logic [9:0] word);
		int n;
		// Acquire on an all-zero word: one rising pair per frame, so no false boundary
		@(posedge ref_clk);
		out_edge_select <= sel;
		parallel_in <= 10'h000;
		run <= 1'b1;
		wait_lock(1'b0, 3000);
		chk({31'h0, parallel_out_oe_n}, 32'h0000_0000);
		@(posedge ref_clk);
		parallel_in <= word;
		n = 0;
		while (recovered_clk === ~sel && n < 200) begin
			@(posedge ref_clk);
			n++;
		end
		#1 chk({31'h0, rclk_pin}, {31'h0, sel});
		repeat (250) @(posedge ref_clk);
		chk({22'h0, rout_pins}, {22'h0, word});
		parallel_in <= ~word;
		repeat (200) @(posedge ref_clk);
		chk({22'h0, rout_pins}, {22'h0, ~word});
		chk_reg(deser_pkg::OFS_STATE, 32'h0000_0002);
		$display("test lock done");
	endtask

	task automatic t_irq();
		chk_reg(deser_pkg::OFS_STATUS, 32'h0000_0001);
		chk({31'h0, irq}, 32'h0000_0000);
		reg_write(deser_pkg::OFS_MASK, 32'h0000_0001);
		repeat (2) @(posedge ref_clk);
		chk({31'h0, irq}, 32'h0000_0001);
		reg_write(deser_pkg::OFS_STATUS, 32'h0000_0001);
		repeat (2) @(posedge ref_clk);
		chk({31'h0, irq}, 32'h0000_0000);
		chk_reg(deser_pkg::OFS_STATUS, 32'h0000_0000);
		chk_reg(8'h10, 32'h0000_0000);
		$display("test irq done");
	endtask

	task automatic t_loss();
		@(posedge ref_clk);
		inject <= 1'b1;
		wait_lock(1'b1, 400);
		@(posedge ref_clk);
		inject <= 1'b0;
		chk({22'h0, rout_pins}, {22'h0, {10{1'bz}}});
		chk({31'h0, rclk_pin}, {31'h0, 1'bz});
		chk_reg(deser_pkg::OFS_STATE, 32'h0000_0007);
		chk_reg(deser_pkg::OFS_STATUS, 32'h0000_0006);
		reg_write(deser_pkg::OFS_STATUS, 32'h0000_0007);
		$display("test loss done");
	endtask

	task automatic t_pins();
		@(posedge ref_clk);
		out_enable <= 1'b0;
		repeat (10) @(posedge ref_clk);
		chk({30'h0, lock_n, parallel_out_oe_n}, 32'h0000_0001);
		out_enable <= 1'b1;
		reg_write(deser_pkg::OFS_CTRL, 32'h0000_0001);
		wait_lock(1'b1, 20);
		chk_reg(deser_pkg::OFS_CTRL, 32'h0000_0001);
		reg_write(deser_pkg::OFS_CTRL, 32'h0000_0000);
		wait_lock(1'b0, 3000);
		@(posedge ref_clk);
		power_down_n <= 1'b0;
		repeat (10) @(posedge ref_clk);
		chk_reg(deser_pkg::OFS_STATE, 32'h0000_0004);
		power_down_n <= 1'b1;
		$display("test pins done");
	endtask

	task automatic test_done();
		$display("compared %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	// Roughly three and a half thousand cycles expected; cut off at 40000, well beyond that
	initial begin
		#1_000_000;
		err_total++;
		test_done();
	end

	initial begin
		err_total = 0;
		n_compared = 0;
		rst = 1'b1;
		power_down_n = 1'b0;
		out_enable = 1'b1;
		out_edge_select = 1'b1;
		reg_addr = 8'h00;
		reg_wdata = 32'h0000_0000;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		parallel_in = 10'h2a5;
		run = 1'b0;
		inject = 1'b0;
		repeat (8) @(posedge ref_clk);
		rst <= 1'b0;
		t_reset();
		t_lock(1'b1, 10'h2a5);
		t_irq();
		t_loss();
		t_lock(1'b0, 10'h1c3);
		t_pins();
		test_done();
	end
endmodule
`default_nettype wire
